//--- pkg/wdt_cfg_pkg.sv
// Purpose: Constants for the configuration-port watchdog block
// Assumes: 20 MHz clock, host I/O cycles presented as single-cycle strobes
// Notes: Unit prescale counts derive from the clock rate
package wdt_cfg_pkg;
  localparam logic [15:0] INDEX_PORT_ADDR = 16'h002E;
  localparam logic [15:0] DATA_PORT_ADDR = 16'h002F;
  localparam logic [7:0] UNLOCK_KEY = 8'h87;
  localparam logic [7:0] LOCK_KEY = 8'hAA;
  localparam logic [7:0] LDN_INDEX = 8'h07;
  localparam logic [7:0] ACTIVATE_INDEX = 8'h30;
  localparam logic [7:0] UNIT_CTRL_INDEX = 8'hF5;
  localparam logic [7:0] COUNTDOWN_INDEX = 8'hF6;
  localparam logic [7:0] WDT_LDN = 8'h08;
  localparam int ACTIVATE_EN_BIT = 0;
  localparam int UNIT_MIN_BIT = 3;
  localparam logic [7:0] LDN_RESET = 8'h00;
  localparam logic [7:0] ACTIVATE_RESET = 8'h00;
  localparam logic [7:0] UNIT_CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNTDOWN_RESET = 8'h00;
  localparam int CLK_HZ = 20000000;
  localparam int SECOND_S = 1;
  localparam int SECONDS_PER_MINUTE = 60;
  localparam int SECOND_CYCLES = CLK_HZ * SECOND_S;
  localparam logic [7:0] READ_IDLE = 8'hFF;
endpackage : wdt_cfg_pkg

//--- src/wdt_tick_divider.sv
// Purpose: Divides the clock into a one-cycle enable every LIMIT cycles
// Assumes: clear restarts the count so the first tick is a full period away
// Notes: Instantiated for the second rate only; the minute rate is counted from its ticks inside lpc_config_watchdog
`timescale 1ns/1ps
module wdt_tick_divider #(
  parameter int LIMIT = 20000000
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  input wire logic clear_i,
  output logic tick_o
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (clear_i || !en_i)
    begin
      nxt_cnt = 32'h0;
    end
    else if (cnt_ff == 32'(LIMIT - 1))
    begin
      nxt_cnt = 32'h0;
      nxt_tick = 1'b1;
    end
    else
    begin
      nxt_cnt = cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cnt_ff <= 32'h0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;
endmodule : wdt_tick_divider

//--- src/lpc_config_watchdog.sv
// Purpose: Watchdog reached through an index/data configuration port pair
// Assumes: Host I/O cycles arrive as one-cycle write/read strobes with address and data
// Notes: One second divider feeds both count units
// Behaviour
// - Registers are reached by writing an index to the index port then using the data port.
// - Writing the unlock key to the index port enters configuration mode, needed for any access.
// - Writing 0x08 to index 0x07 selects the watchdog register set for later accesses.
// - Writing 0x01 to index 0x30 of the watchdog device enables the watchdog.
// - Index 0xF5 selects the count unit, 0x00 for seconds and 0x08 for minutes.
// - Index 0xF6 takes an 8-bit timeout value 0x01 to 0xFF in the chosen unit; 0x00 stops the countdown.
// - Each write of the counter register restarts the countdown from the new value.
`timescale 1ns/1ps
module lpc_config_watchdog #(
  parameter int SECOND_CYCLES = wdt_cfg_pkg::SECOND_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  output logic watchdog_timeout_output_n
);
  // ----------------------------------------
  // Port decode
  // ----------------------------------------
  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  logic wdt_sel;
  logic cfg_mode_ff;
  logic nxt_cfg_mode;
  logic [7:0] index_ff;
  logic [7:0] nxt_index;
  logic [7:0] ldn_ff;
  logic [7:0] nxt_ldn;
  logic [7:0] act_ff;
  logic [7:0] nxt_act;
  logic [7:0] unit_ff;
  logic [7:0] nxt_unit;
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic timeout_n_ff;
  logic nxt_fired;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic count_wr;
  logic enabled;
  logic running;
  logic sec_tick;
  logic unit_tick;
  logic [5:0] min_cnt_ff;
  logic [5:0] nxt_min_cnt;
  logic min_tick_ff;
  logic nxt_min_tick;

  assign idx_wr = io_wr_i && (io_addr_i == wdt_cfg_pkg::INDEX_PORT_ADDR);
  assign dat_wr = io_wr_i && (io_addr_i == wdt_cfg_pkg::DATA_PORT_ADDR) && cfg_mode_ff;
  assign dat_rd = io_rd_i && (io_addr_i == wdt_cfg_pkg::DATA_PORT_ADDR) && cfg_mode_ff;
  assign wdt_sel = (ldn_ff == wdt_cfg_pkg::WDT_LDN);
  assign count_wr = dat_wr && wdt_sel && (index_ff == wdt_cfg_pkg::COUNTDOWN_INDEX);
  assign enabled = act_ff[wdt_cfg_pkg::ACTIVATE_EN_BIT];
  assign running = enabled && (count_ff != 8'h00);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_comb
  begin
    nxt_cfg_mode = cfg_mode_ff;
    nxt_index = index_ff;
    nxt_ldn = ldn_ff;
    nxt_act = act_ff;
    nxt_unit = unit_ff;
    if (idx_wr)
    begin
      if (!cfg_mode_ff && io_wdata_i == wdt_cfg_pkg::UNLOCK_KEY)
      begin
        nxt_cfg_mode = 1'b1;
      end
      else if (cfg_mode_ff && io_wdata_i == wdt_cfg_pkg::LOCK_KEY)
      begin
        nxt_cfg_mode = 1'b0;
      end
      else if (cfg_mode_ff)
      begin
        nxt_index = io_wdata_i;
      end
    end
    if (dat_wr)
    begin
      if (index_ff == wdt_cfg_pkg::LDN_INDEX)
      begin
        nxt_ldn = io_wdata_i;
      end
      else if (wdt_sel && index_ff == wdt_cfg_pkg::ACTIVATE_INDEX)
      begin
        nxt_act = io_wdata_i;
      end
      else if (wdt_sel && index_ff == wdt_cfg_pkg::UNIT_CTRL_INDEX)
      begin
        nxt_unit = io_wdata_i;
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb
  begin
    nxt_rvalid = io_rd_i;
    nxt_rdata = wdt_cfg_pkg::READ_IDLE;
    if (io_rd_i && io_addr_i == wdt_cfg_pkg::INDEX_PORT_ADDR && cfg_mode_ff)
    begin
      nxt_rdata = index_ff;
    end
    else if (dat_rd)
    begin
      if (index_ff == wdt_cfg_pkg::LDN_INDEX)
      begin
        nxt_rdata = ldn_ff;
      end
      else if (wdt_sel && index_ff == wdt_cfg_pkg::ACTIVATE_INDEX)
      begin
        nxt_rdata = act_ff;
      end
      else if (wdt_sel && index_ff == wdt_cfg_pkg::UNIT_CTRL_INDEX)
      begin
        nxt_rdata = unit_ff;
      end
      else if (wdt_sel && index_ff == wdt_cfg_pkg::COUNTDOWN_INDEX)
      begin
        nxt_rdata = count_ff;
      end
      else
      begin
        nxt_rdata = 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  wdt_tick_divider #(
    .LIMIT(SECOND_CYCLES)
  ) u_sec_div (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .en_i(running),
    .clear_i(count_wr),
    .tick_o(sec_tick)
  );

  always_comb
  begin
    nxt_min_cnt = min_cnt_ff;
    nxt_min_tick = 1'b0;
    if (count_wr || !running)
    begin
      nxt_min_cnt = 6'h00;
    end
    else if (sec_tick)
    begin
      if (min_cnt_ff == 6'(wdt_cfg_pkg::SECONDS_PER_MINUTE - 1))
      begin
        nxt_min_cnt = 6'h00;
        nxt_min_tick = 1'b1;
      end
      else
      begin
        nxt_min_cnt = min_cnt_ff + 6'h01;
      end
    end
  end

  assign unit_tick = unit_ff[wdt_cfg_pkg::UNIT_MIN_BIT] ? min_tick_ff : sec_tick;

  // ----------------------------------------
  // Countdown and expiry
  // ----------------------------------------
  always_comb
  begin
    nxt_count = count_ff;
    nxt_fired = ~timeout_n_ff;
    if (count_wr)
    begin
      nxt_count = io_wdata_i;
      nxt_fired = 1'b0;
    end
    else if (running && unit_tick && !count_wr)
    begin
      nxt_count = count_ff - 8'h01;
      if (count_ff == 8'h01)
      begin
        nxt_fired = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cfg_mode_ff <= 1'b0;
      index_ff <= 8'h00;
      ldn_ff <= wdt_cfg_pkg::LDN_RESET;
      act_ff <= wdt_cfg_pkg::ACTIVATE_RESET;
      unit_ff <= wdt_cfg_pkg::UNIT_CTRL_RESET;
      count_ff <= wdt_cfg_pkg::COUNTDOWN_RESET;
      timeout_n_ff <= 1'b1;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      min_cnt_ff <= 6'h00;
      min_tick_ff <= 1'b0;
    end
    else
    begin
      cfg_mode_ff <= nxt_cfg_mode;
      index_ff <= nxt_index;
      ldn_ff <= nxt_ldn;
      act_ff <= nxt_act;
      unit_ff <= nxt_unit;
      count_ff <= nxt_count;
      timeout_n_ff <= ~(nxt_fired && enabled);
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      min_cnt_ff <= nxt_min_cnt;
      min_tick_ff <= nxt_min_tick;
    end
  end

  assign io_rdata_o = rdata_ff;
  assign io_rvalid_o = rvalid_ff;
  assign watchdog_timeout_output_n = timeout_n_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_unlock;
    idx_wr && !cfg_mode_ff && io_wdata_i == wdt_cfg_pkg::UNLOCK_KEY;
  endsequence
  property p_unlock;
    @(posedge clk_i) disable iff (!resetn_i) s_unlock |=> cfg_mode_ff;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock key did not enter config mode");

  property p_locked_ignore;
    @(posedge clk_i) disable iff (!resetn_i)
      (!cfg_mode_ff && io_wr_i && io_addr_i == wdt_cfg_pkg::DATA_PORT_ADDR) |=> $stable(ldn_ff) && $stable(act_ff);
  endproperty
  a_locked_ignore: assert property (p_locked_ignore) else $error("data write accepted while locked");

  property p_index;
    @(posedge clk_i) disable iff (!resetn_i)
      (idx_wr && cfg_mode_ff && io_wdata_i != wdt_cfg_pkg::LOCK_KEY) |=> index_ff == $past(io_wdata_i);
  endproperty
  a_index: assert property (p_index) else $error("index port write not stored");

  property p_ldn;
    @(posedge clk_i) disable iff (!resetn_i)
      (dat_wr && index_ff == wdt_cfg_pkg::LDN_INDEX) |=> ldn_ff == $past(io_wdata_i);
  endproperty
  a_ldn: assert property (p_ldn) else $error("device select not stored");

  property p_activate;
    @(posedge clk_i) disable iff (!resetn_i)
      (dat_wr && wdt_sel && index_ff == wdt_cfg_pkg::ACTIVATE_INDEX) |=> act_ff == $past(io_wdata_i);
  endproperty
  a_activate: assert property (p_activate) else $error("activation not stored");

  property p_unit;
    @(posedge clk_i) disable iff (!resetn_i)
      (dat_wr && !wdt_sel) |=> $stable(unit_ff) && $stable(act_ff);
  endproperty
  a_unit: assert property (p_unit) else $error("watchdog register written without selection");

  property p_reload;
    @(posedge clk_i) disable iff (!resetn_i)
      count_wr |=> count_ff == $past(io_wdata_i) && watchdog_timeout_output_n;
  endproperty
  a_reload: assert property (p_reload) else $error("counter write did not restart countdown");

  property p_expire;
    @(posedge clk_i) disable iff (!resetn_i)
      (running && unit_tick && count_ff == 8'h01 && !count_wr) |=> !watchdog_timeout_output_n;
  endproperty
  a_expire: assert property (p_expire) else $error("timeout not asserted at zero");
  property p_no_fire_disabled;
    @(posedge clk_i) disable iff (!resetn_i) !enabled |=> watchdog_timeout_output_n;
  endproperty
  a_no_fire_disabled: assert property (p_no_fire_disabled) else $error("timeout asserted while disabled");
endmodule : lpc_config_watchdog

//--- verif/host_io_model.sv
// Purpose: Host model issuing index/data port cycles
// Assumes: One-cycle strobes launched on the rising edge
// Notes: Idle address and data show the inverse of the last value
`timescale 1ns/1ps
module host_io_model (
  input wire logic clk_i,
  input wire logic [7:0] io_rdata_i,
  input wire logic io_rvalid_i,
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [15:0] io_addr_o,
  output logic [7:0] io_wdata_o
);
  initial
  begin
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_addr_o = 16'h0000;
    io_wdata_o = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    io_wr_o <= 1'b1;
    io_addr_o <= a;
    io_wdata_o <= d;
    @(posedge clk_i);
    io_wr_o <= 1'b0;
    io_addr_o <= ~a;
    io_wdata_o <= ~d;
    // Let the write's effect settle before the caller looks at outputs
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_i);
    io_rd_o <= 1'b1;
    io_addr_o <= a;
    @(posedge clk_i);
    io_rd_o <= 1'b0;
    io_addr_o <= ~a;
    #1;
    d = io_rdata_i;
    v = io_rvalid_i;
  endtask : rd
  task automatic unlock();
    wr(wdt_cfg_pkg::INDEX_PORT_ADDR, wdt_cfg_pkg::UNLOCK_KEY);
  endtask : unlock
  // Index first, then the data port
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    wr(wdt_cfg_pkg::INDEX_PORT_ADDR, i);
    wr(wdt_cfg_pkg::DATA_PORT_ADDR, d);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] i, output logic [7:0] d, output logic v);
    wr(wdt_cfg_pkg::INDEX_PORT_ADDR, i);
    rd(wdt_cfg_pkg::DATA_PORT_ADDR, d, v);
  endtask : reg_rd
endmodule : host_io_model

//--- verif/testbench.sv
// Purpose: Self-checking bench for the configuration-port watchdog
// Assumes: SECOND_CYCLES shrunk to 4, minute is 240 cycles
// Notes: Each scenario task judges its own results
`timescale 1ns/1ps
module testbench;
  localparam int SC = 4;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic wr, rd, rv, tout_n, v;
  logic [15:0] addr;
  logic [7:0] wd, rdata, d;
  int bad_count = 0;
  int checked = 0;
  int n;
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  host_io_model host (.clk_i(clk_i), .io_rdata_i(rdata), .io_rvalid_i(rv), .io_wr_o(wr), .io_rd_o(rd),
    .io_addr_o(addr), .io_wdata_o(wd));
  lpc_config_watchdog #(.SECOND_CYCLES(SC)) DUT (.clk_i(clk_i), .resetn_i(resetn_i), .io_wr_i(wr),
    .io_rd_i(rd), .io_addr_i(addr), .io_wdata_i(wd), .io_rdata_o(rdata), .io_rvalid_o(rv),
    .watchdog_timeout_output_n(tout_n));
  // ----------------------------------------
  // Compare and wait helpers
  // ----------------------------------------
  task automatic give_verdict();
    $display("Compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1
  task automatic rchk(input logic [7:0] i, input logic [7:0] e);
    host.reg_rd(i, d, v);
    chk1(v, 1'b1);
    chk8(d, e);
  endtask : rchk
  // Cycles until the output goes low; must=1 makes running out a failure
  task automatic wait_low(input int lim, input logic must, output int c);
    for (c = 0; c < lim; c++)
    begin
      @(posedge clk_i);
      #1;
      if (tout_n !== 1'b1)
        break;
    end
    if (must && c == lim)
    begin
      bad_count++;
      $display("[FAIL] t=%0t wait %h exp %h", $time, c, 1'b0);
      give_verdict();
    end
  endtask : wait_low
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_locked();
    chk1(tout_n, 1'b1);
    host.reg_wr(wdt_cfg_pkg::LDN_INDEX, wdt_cfg_pkg::WDT_LDN);
    rchk(wdt_cfg_pkg::LDN_INDEX, wdt_cfg_pkg::READ_IDLE);
    host.rd(16'h0080, d, v);
    chk8(d, wdt_cfg_pkg::READ_IDLE);
  endtask : t_locked
  task automatic t_select();
    host.unlock();
    rchk(wdt_cfg_pkg::LDN_INDEX, 8'h00);
    host.reg_wr(wdt_cfg_pkg::ACTIVATE_INDEX, 8'h01);
    rchk(wdt_cfg_pkg::ACTIVATE_INDEX, 8'h00);
    host.reg_wr(wdt_cfg_pkg::LDN_INDEX, wdt_cfg_pkg::WDT_LDN);
    rchk(wdt_cfg_pkg::LDN_INDEX, 8'h08);
    host.reg_wr(wdt_cfg_pkg::ACTIVATE_INDEX, 8'h01);
    rchk(wdt_cfg_pkg::ACTIVATE_INDEX, 8'h01);
  endtask : t_select
  task automatic t_expire_sec();
    host.reg_wr(wdt_cfg_pkg::UNIT_CTRL_INDEX, 8'h00);
    host.reg_wr(wdt_cfg_pkg::COUNTDOWN_INDEX, 8'h02);
    wait_low(40, 1'b1, n);
    chk1(n >= 2 * SC && n <= 2 * SC + 3, 1'b1);
  endtask : t_expire_sec
  task automatic t_reload();
    host.reg_wr(wdt_cfg_pkg::COUNTDOWN_INDEX, 8'h03);
    host.rd(wdt_cfg_pkg::DATA_PORT_ADDR, d, v);
    chk8(d, 8'h03);
    chk1(tout_n, 1'b1);
    wait_low(60, 1'b1, n);
    chk1(n >= 3 * SC - 4 && n <= 3 * SC, 1'b1);
  endtask : t_reload
  task automatic t_minute();
    host.reg_wr(wdt_cfg_pkg::UNIT_CTRL_INDEX, 8'h08);
    rchk(wdt_cfg_pkg::UNIT_CTRL_INDEX, 8'h08);
    host.reg_wr(wdt_cfg_pkg::COUNTDOWN_INDEX, 8'h01);
    chk1(tout_n, 1'b1);
    wait_low(400, 1'b1, n);
    chk1(n >= 60 * SC - 3 && n <= 60 * SC + 3, 1'b1);
  endtask : t_minute
  task automatic t_stop();
    host.reg_wr(wdt_cfg_pkg::COUNTDOWN_INDEX, 8'h00);
    wait_low(300, 1'b0, n);
    chk1(n == 300, 1'b1);
    host.reg_wr(wdt_cfg_pkg::UNIT_CTRL_INDEX, 8'h00);
    host.reg_wr(wdt_cfg_pkg::ACTIVATE_INDEX, 8'h00);
    host.reg_wr(wdt_cfg_pkg::COUNTDOWN_INDEX, 8'h01);
    wait_low(20, 1'b0, n);
    chk1(n == 20, 1'b1);
    host.wr(wdt_cfg_pkg::INDEX_PORT_ADDR, wdt_cfg_pkg::LOCK_KEY);
    host.rd(wdt_cfg_pkg::DATA_PORT_ADDR, d, v);
    chk8(d, wdt_cfg_pkg::READ_IDLE);
  endtask : t_stop
  initial
  begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk1(rv, 1'b0);
    t_locked();
    t_select();
    t_expire_sec();
    t_reload();
    t_minute();
    t_stop();
    give_verdict();
  end
endmodule : testbench
